// ==== hdl/flash_setup_pkg.sv ====
// Shared constants and carrier types for the flash set-up and status block.
// Assumes a 32-bit register port with byte addresses and a single clock.
package flash_setup_pkg;

    // Register byte addresses
    localparam logic [31:0] SETUP_INIT_OFS = 32'hffa1008c;
    localparam logic [31:0] LOCK_STAT_OFS  = 32'hffa10090;
    localparam logic [31:0] FIRST_ERR_OFS  = 32'hffa10094;
    localparam logic [31:0] XFER_STAT_OFS  = 32'hffa10098;
    localparam logic [31:0] IRQ_STAT_OFS   = 32'hffa100a0;
    localparam logic [31:0] IRQ_MASK_OFS   = 32'hffa100a4;

    // Field positions
    localparam int KEY_MSB        = 15;
    localparam int KEY_LSB        = 8;
    localparam int SETUP_INIT_POS = 0;
    localparam int LOCK_BIT_POS   = 0;
    localparam int ERR_ADDR_W     = 12;
    localparam int XFER_SGL_POS   = 0;
    localparam int XFER_DBL_POS   = 1;

    // Interrupt event positions, same layout in status and mask
    localparam int EV_LOCK_DONE = 0;
    localparam int EV_RAM_ERR   = 1;
    localparam int EV_XFER_SGL  = 2;
    localparam int EV_XFER_DBL  = 3;
    localparam int EV_W         = 4;

    // Key and reset values
    localparam logic [7:0]            SETUP_KEY      = 8'h2d;
    localparam logic                  SETUP_INIT_RST = 1'b0;
    localparam logic                  LOCK_STAT_RST  = 1'b0;
    localparam logic [ERR_ADDR_W-1:0] ERR_ADDR_RST   = 12'h000;
    localparam logic [1:0]            XFER_STAT_RST  = 2'h0;
    localparam logic [EV_W-1:0]       IRQ_STAT_RST   = 4'h0;
    localparam logic [EV_W-1:0]       IRQ_MASK_RST   = 4'h0;

    // Register port request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Result of the configuration transfer done at reset
    typedef struct packed {
        logic done;
        logic double_err;
        logic single_corr;
    } xfer_result_t;

    // ECC error report from the sequencer work RAM
    typedef struct packed {
        logic                  err;
        logic [ERR_ADDR_W-1:0] offset;
    } ram_err_t;

    // Lock-bit read tracking
    typedef enum logic [0:0] {
        LK_IDLE = 1'b0,
        LK_WAIT = 1'b1
    } lock_state_t;

endpackage : flash_setup_pkg

// ==== hdl/reset_release_sync.sv ====
// Reset release synchroniser for the flash set-up block.
// Assumes reset_n may fall at any time; release is aligned to clock.
`timescale 1ns/100ps
`default_nettype none
module reset_release_sync (
    input  wire logic clock,
    input  wire logic reset_n,
    output logic      rst_sync_n
);
    logic meta_q;

    // Assert at once, release after two edges to avoid metastability
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q     <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            meta_q     <= 1'b1;
            rst_sync_n <= meta_q;
        end
    end
endmodule : reset_release_sync
`default_nettype wire

// ==== hdl/flash_setup_status_regs.sv ====
// Flash sequencer set-up initialization and status registers.
// Assumes software on a plain strobe port, read data one cycle later,
// and sequencer inputs synchronous to clock.
//
// What this block does
// - Key field bits 15..8 store nothing and always read zero.
// - Set-up init bit writes accepted only while sequencer ready is 1.
// - Init bit changes only when the same write carries key 2d hex.
// - Writing init bit 1 resets the six set-up registers; 0 only stores 0 in the bit.
// - Reserved bits read 0; software writes only 0 to them.
// - Lock status captured when ready rises after lock read, then held.
// - Lock status reads 0 for protected area, 1 for unprotected.
// - Transfer status is read-only; bit 1 flags a 2-bit error.
// - Transfer status bit 0 flags a corrected 1-bit error.
// - Transfer error flags never cause the command lock state.
// - 2-bit flag clears at reset; only the first transfer after reset can set it.
// - 1-bit flag clears at reset; only the first transfer after reset can set it.
`timescale 1ns/100ps
`default_nettype none
module flash_setup_status_regs (
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire flash_setup_pkg::reg_req_t    req,
    output logic [31:0]                       rdata,
    input  wire logic                         sequencer_ready_flag,
    input  wire logic                         lock_read_issued,
    input  wire logic                         lock_area_protected,
    input  wire flash_setup_pkg::ram_err_t    ram_err,
    input  wire flash_setup_pkg::xfer_result_t xfer,
    input  wire logic                         other_lock_cause,
    output logic                              cmd_lock_enter,
    output logic                              setup_regs_init,
    output logic                              irq
);
    import flash_setup_pkg::*;

    logic                  rst_n;
    logic                  setup_init_bit_q;
    logic                  setup_regs_init_q;
    logic                  ready_prev_q;
    lock_state_t           lock_state_q;
    lock_state_t           lock_state_d;
    logic                  lock_status_bit_q;
    logic                  err_seen_q;
    logic [ERR_ADDR_W-1:0] err_addr_q;
    logic                  xfer_seen_q;
    logic                  dbl_flag_q;
    logic                  sgl_flag_q;
    logic [EV_W-1:0]       irq_stat_q;
    logic [EV_W-1:0]       irq_stat_d;
    logic [EV_W-1:0]       irq_mask_q;
    logic [EV_W-1:0]       events;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  setup_wr;
    logic                  key_ok;
    logic                  init_accept;
    logic                  ready_rise;
    logic                  lock_done;
    logic                  first_err;
    logic                  xfer_first;

    // Register port address match, used by every decode below
    function automatic logic hit(input logic [31:0] addr,
                                 input logic [31:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Reset released through two flops
    reset_release_sync u_rst (
        .clock      (clock),
        .reset_n    (reset_n),
        .rst_sync_n (rst_n)
    );

    // Key-guarded write qualification for the set-up init register
    assign setup_wr    = req.wr && hit(req.addr, SETUP_INIT_OFS);
    assign key_ok      = (req.wdata[KEY_MSB:KEY_LSB] == SETUP_KEY);
    assign init_accept = setup_wr && key_ok && sequencer_ready_flag;

    // Init bit keeps the last accepted value; key bits are never stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            setup_init_bit_q <= SETUP_INIT_RST;
        end else if (init_accept) begin
            setup_init_bit_q <= req.wdata[SETUP_INIT_POS];
        end
    end

    // One-cycle init pulse to the six set-up registers on an accepted 1
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            setup_regs_init_q <= 1'b0;
        end else begin
            setup_regs_init_q <= init_accept
                                 && req.wdata[SETUP_INIT_POS];
        end
    end
    assign setup_regs_init = setup_regs_init_q;

    // Ready edge detect; ready is already synchronous
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_prev_q <= 1'b1;
        end else begin
            ready_prev_q <= sequencer_ready_flag;
        end
    end
    assign ready_rise = sequencer_ready_flag && !ready_prev_q;
    assign lock_done  = (lock_state_q == LK_WAIT) && ready_rise;

    // Lock read tracker: waits for ready to come back after the command
    always_comb begin
        lock_state_d = lock_state_q;
        unique case (lock_state_q)
            LK_IDLE: begin
                if (lock_read_issued) begin
                    lock_state_d = LK_WAIT;
                end
            end
            LK_WAIT: begin
                if (ready_rise && !lock_read_issued) begin
                    lock_state_d = LK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_state_q <= LK_IDLE;
        end else begin
            lock_state_q <= lock_state_d;
        end
    end

    // Lock status: 1 means unprotected, so the protect level is inverted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_status_bit_q <= LOCK_STAT_RST;
        end else if (lock_done) begin
            lock_status_bit_q <= !lock_area_protected;
        end
    end

    // First work RAM ECC error; later errors do not overwrite it
    assign first_err = ram_err.err && !err_seen_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err_seen_q <= 1'b0;
            err_addr_q <= ERR_ADDR_RST;
        end else if (first_err) begin
            err_seen_q <= 1'b1;
            err_addr_q <= ram_err.offset;
        end
    end

    // Transfer result taken once per reset; reset clears the flags,
    // and only the first transfer after reset can set them again
    assign xfer_first = xfer.done && !xfer_seen_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xfer_seen_q <= 1'b0;
            dbl_flag_q  <= XFER_STAT_RST[XFER_DBL_POS];
            sgl_flag_q  <= XFER_STAT_RST[XFER_SGL_POS];
        end else if (xfer_first) begin
            xfer_seen_q <= 1'b1;
            dbl_flag_q  <= xfer.double_err;
            sgl_flag_q  <= xfer.single_corr;
        end
    end

    // Command lock driven by other causes only, never by transfer flags
    assign cmd_lock_enter = other_lock_cause;

    // Interrupt events, one bit each
    always_comb begin
        events               = '0;
        events[EV_LOCK_DONE] = lock_done;
        events[EV_RAM_ERR]   = first_err;
        events[EV_XFER_SGL]  = xfer_first && xfer.single_corr;
        events[EV_XFER_DBL]  = xfer_first && xfer.double_err;
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (req.wr && hit(req.addr, IRQ_STAT_OFS)) begin
            irq_stat_d = irq_stat_q & ~req.wdata[EV_W-1:0];
        end
        irq_stat_d = irq_stat_d | events;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= IRQ_STAT_RST;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Mask register, plain read/write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (req.wr && hit(req.addr, IRQ_MASK_OFS)) begin
            irq_mask_q <= req.wdata[EV_W-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Read mux; reserved bits and unmapped addresses give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(req.addr, SETUP_INIT_OFS)) begin
            rdata_d[SETUP_INIT_POS] = setup_init_bit_q;
        end else if (hit(req.addr, LOCK_STAT_OFS)) begin
            rdata_d[LOCK_BIT_POS] = lock_status_bit_q;
        end else if (hit(req.addr, FIRST_ERR_OFS)) begin
            rdata_d[ERR_ADDR_W-1:0] = err_addr_q;
        end else if (hit(req.addr, XFER_STAT_OFS)) begin
            rdata_d[XFER_DBL_POS] = dbl_flag_q;
            rdata_d[XFER_SGL_POS] = sgl_flag_q;
        end else if (hit(req.addr, IRQ_STAT_OFS)) begin
            rdata_d[EV_W-1:0] = irq_stat_q;
        end else if (hit(req.addr, IRQ_MASK_OFS)) begin
            rdata_d[EV_W-1:0] = irq_mask_q;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign rdata = rdata_q;

    // Checks on the design's own outputs and state
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_lock_cmd;
        lock_read_issued && (lock_state_q == LK_IDLE);
    endsequence

    sequence s_lock_complete;
        (lock_state_q == LK_WAIT) && sequencer_ready_flag && !ready_prev_q;
    endsequence

    // Accepted set-up write that asks for initialization
    sequence s_good_init;
        setup_wr && sequencer_ready_flag && key_ok
            && req.wdata[SETUP_INIT_POS];
    endsequence

    a_key_reads_zero: assert property (
        (req.rd && hit(req.addr, SETUP_INIT_OFS)) |=> (rdata[15:1] == 15'h0)
    ) else $error("set-up key or reserved bits read nonzero");

    a_init_pulse_cause: assert property (
        setup_regs_init |-> $past(setup_wr && sequencer_ready_flag
            && key_ok && req.wdata[SETUP_INIT_POS])
    ) else $error("set-up init pulse without a valid write of 1");

    // Back-to-back accepted writes each give their own pulse
    a_init_on_good_write: assert property (
        s_good_init |=> setup_regs_init
            ##1 (!setup_regs_init
                 || $past(init_accept && req.wdata[SETUP_INIT_POS]))
    ) else $error("accepted init write gave no single pulse");

    a_bad_write_ignored: assert property (
        (setup_wr && (!sequencer_ready_flag || !key_ok))
            |=> ($stable(setup_init_bit_q) && !setup_regs_init)
    ) else $error("set-up write taken while busy or with bad key");

    a_lock_capture: assert property (
        s_lock_cmd |=> (lock_state_q == LK_WAIT)
    ) else $error("lock read command not tracked");

    a_lock_value: assert property (
        s_lock_complete |=> (lock_status_bit_q == !$past(lock_area_protected))
    ) else $error("lock status does not match read result");

    a_lock_hold: assert property (
        !lock_done |=> $stable(lock_status_bit_q)
    ) else $error("lock status changed without a lock read completing");

    a_first_err_kept: assert property (
        (ram_err.err && !err_seen_q) |=> (err_addr_q == $past(ram_err.offset))
            ##1 (err_seen_q && $stable(err_addr_q))
    ) else $error("first work RAM error offset not kept");

    a_xfer_flags_sticky: assert property (
        xfer_seen_q |=> ($stable(dbl_flag_q) && $stable(sgl_flag_q))
    ) else $error("transfer flags changed without a reset");

    a_xfer_flag_read: assert property (
        (req.rd && hit(req.addr, XFER_STAT_OFS))
            |=> (rdata == {30'h0, $past(dbl_flag_q), $past(sgl_flag_q)})
    ) else $error("transfer status read wrong");

    a_no_flag_lock: assert property (
        ((dbl_flag_q || sgl_flag_q) && !other_lock_cause) |-> !cmd_lock_enter
    ) else $error("transfer flag drove command lock");

    a_irq_set_wins: assert property (
        (|events && req.wr && hit(req.addr, IRQ_STAT_OFS))
            |=> ((irq_stat_q & $past(events)) == $past(events))
    ) else $error("event lost to a simultaneous clear");

    // Read checks use the value seen at the strobe edge, as the mux did
    a_xfer_capture: assert property (
        xfer.done && !xfer_seen_q
            |=> (dbl_flag_q == $past(xfer.double_err))
                && (sgl_flag_q == $past(xfer.single_corr))
    ) else $error("transfer result not captured");

    a_lock_stat_read: assert property (
        (req.rd && hit(req.addr, LOCK_STAT_OFS))
            |=> (rdata == {31'h0, $past(lock_status_bit_q)})
    ) else $error("lock status read wrong");

    a_err_addr_read: assert property (
        (req.rd && hit(req.addr, FIRST_ERR_OFS))
            |=> (rdata == {20'h0, $past(err_addr_q)})
    ) else $error("first error address read wrong");

    a_rdata_idle: assert property (
        !req.rd |=> (rdata == 32'h0000_0000)
    ) else $error("read data stood outside the read cycle");

endmodule : flash_setup_status_regs
`default_nettype wire

// ==== tb/flash_setup_status_regs_tb_top.sv ====
// Self-checking bench for the flash set-up and status register block.
// Assumes the design package is compiled first; bench drives every port.
`timescale 1ns/100ps
`default_nettype none
module flash_setup_status_regs_tb_top;
    import flash_setup_pkg::*;

    logic                clock;
    logic                reset_n;
    reg_req_t            req;
    logic [31:0]         rdata;
    logic                sequencer_ready_flag;
    logic                lock_read_issued;
    logic                lock_area_protected;
    ram_err_t            ram_err;
    xfer_result_t        xfer;
    logic                other_lock_cause;
    logic                cmd_lock_enter;
    logic                setup_regs_init;
    logic                irq;
    int                  err_count;
    int                  tests_run;

    flash_setup_status_regs DUT (
        .clock                (clock),
        .reset_n              (reset_n),
        .req                  (req),
        .rdata                (rdata),
        .sequencer_ready_flag (sequencer_ready_flag),
        .lock_read_issued     (lock_read_issued),
        .lock_area_protected  (lock_area_protected),
        .ram_err              (ram_err),
        .xfer                 (xfer),
        .other_lock_cause     (other_lock_cause),
        .cmd_lock_enter       (cmd_lock_enter),
        .setup_regs_init      (setup_regs_init),
        .irq                  (irq)
    );

    // 40 MHz system clock
    always #12.5 clock = ~clock;

    // Compare and count
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Final verdict, reached from the main flow or the watchdog
    task automatic close_out;
        $display("Checks made %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // One-cycle write; init pulse is looked at in the cycle after
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic exp_pulse);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        #1;
        chk("setup_regs_init", {31'h0, exp_pulse}, {31'h0, setup_regs_init});
    endtask : wr

    // One-cycle read; data stands one cycle only, then returns to zero
    task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                      input string name);
        @(posedge clock);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
        @(posedge clock);
        #1;
        chk("rdata idle", 32'h0, rdata);
    endtask : rd

    // Hold reset for ten cycles, then leave room for the release flops
    task automatic do_reset;
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (9) @(posedge clock);
        #1;
        chk("irq in reset", 32'h0, {31'h0, irq});
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : do_reset

    // Transfer-finished pulse with its two result levels
    task automatic xfer_done(input logic dbl, input logic sgl);
        @(posedge clock);
        xfer <= '{done: 1'b1, double_err: dbl, single_corr: sgl};
        @(posedge clock);
        xfer <= '0;
    endtask : xfer_done

    // Lock-bit read: command, busy, then ready rises with the result
    task automatic lock_read(input logic prot);
        @(posedge clock);
        lock_read_issued     <= 1'b1;
        sequencer_ready_flag <= 1'b0;
        lock_area_protected  <= prot;
        @(posedge clock);
        lock_read_issued <= 1'b0;
        repeat (3) @(posedge clock);
        sequencer_ready_flag <= 1'b1;
        repeat (2) @(posedge clock);
        lock_area_protected <= ~prot; // Result must not follow later changes
    endtask : lock_read

    // Watchdog so that no hang goes unreported
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        close_out();
    end

    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        req = '0;
        sequencer_ready_flag = 1'b1;
        lock_read_issued = 1'b0;
        lock_area_protected = 1'b0;
        ram_err = '0;
        xfer = '0;
        other_lock_cause = 1'b0;
        err_count = 0;
        tests_run = 0;
        do_reset();

        // Reset values and unmapped space
        rd(SETUP_INIT_OFS, 32'h0, "setup_init_ctrl");
        rd(LOCK_STAT_OFS, 32'h0, "lock_read_status");
        rd(FIRST_ERR_OFS, 32'h0, "work_ram_first_err_addr");
        rd(IRQ_STAT_OFS, 32'h0, "irq status");
        wr(32'hffa1009c, 32'hffff_ffff, 1'b0);
        rd(32'hffa1009c, 32'h0, "unmapped");
        $display("test reset_values done");

        // Key and ready gating of the init bit
        wr(SETUP_INIT_OFS, 32'h0000_2d00, 1'b0);
        rd(SETUP_INIT_OFS, 32'h0, "setup reserved");
        wr(SETUP_INIT_OFS, 32'h0000_2d01, 1'b1);
        rd(SETUP_INIT_OFS, 32'h1, "setup bit set");
        wr(SETUP_INIT_OFS, 32'h0000_2d01, 1'b1);
        wr(SETUP_INIT_OFS, 32'h0000_5500, 1'b0);
        rd(SETUP_INIT_OFS, 32'h1, "setup bad key");
        wr(SETUP_INIT_OFS, 32'h0000_2d00, 1'b0);
        rd(SETUP_INIT_OFS, 32'h0, "setup cleared");
        @(posedge clock);
        sequencer_ready_flag <= 1'b0;
        wr(SETUP_INIT_OFS, 32'h0000_2d01, 1'b0);
        rd(SETUP_INIT_OFS, 32'h0, "setup busy");
        @(posedge clock);
        sequencer_ready_flag <= 1'b1;
        $display("test setup_init done");

        // Lock status capture and hold; read-only against writes
        lock_read(1'b1);
        rd(LOCK_STAT_OFS, 32'h0, "lock protected");
        lock_read(1'b0);
        rd(LOCK_STAT_OFS, 32'h1, "lock open");
        wr(LOCK_STAT_OFS, 32'h0000_0000, 1'b0);
        rd(LOCK_STAT_OFS, 32'h1, "lock held");
        lock_read(1'b1);
        rd(LOCK_STAT_OFS, 32'h0, "lock protected again");
        $display("test lock_status done");

        // First work RAM error kept, later ones dropped
        @(posedge clock);
        ram_err <= '{err: 1'b1, offset: 12'h5a3};
        @(posedge clock);
        ram_err <= '{err: 1'b1, offset: 12'h0f0};
        @(posedge clock);
        ram_err <= '0;
        rd(FIRST_ERR_OFS, 32'h0000_05a3, "first err addr");
        $display("test ram_error done");

        // Transfer flags set, held, read-only, no command lock
        xfer_done(1'b1, 1'b1);
        xfer_done(1'b0, 1'b0);
        wr(XFER_STAT_OFS, 32'h0, 1'b0);
        rd(XFER_STAT_OFS, 32'h3, "xfer flags");
        chk("cmd_lock_enter", 32'h0, {31'h0, cmd_lock_enter});
        @(posedge clock);
        other_lock_cause <= 1'b1;
        @(posedge clock);
        #1;
        chk("cmd_lock_enter", 32'h1, {31'h0, cmd_lock_enter});
        @(posedge clock);
        other_lock_cause <= 1'b0;
        $display("test xfer_flags done");

        // Events, mask and write-one-to-clear
        rd(IRQ_STAT_OFS, 32'hf, "irq status all");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(IRQ_MASK_OFS, 32'h2, 1'b0);
        @(posedge clock);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(IRQ_STAT_OFS, 32'h2, 1'b0);
        @(posedge clock);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(IRQ_STAT_OFS, 32'hd, "irq status left");
        rd(IRQ_MASK_OFS, 32'h2, "irq mask");
        $display("test interrupts done");

        // Second reset: flags clear at reset and take the next transfer's result;
        // the transfer event lands in the same cycle as a status clear
        do_reset();
        @(posedge clock);
        xfer <= '{done: 1'b1, double_err: 1'b0, single_corr: 1'b1};
        req  <= '{addr: IRQ_STAT_OFS, wdata: 32'h0000_000f, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        xfer   <= '0;
        req.wr <= 1'b0;
        rd(IRQ_STAT_OFS, 32'h4, "irq set beats clear");
        rd(XFER_STAT_OFS, 32'h1, "xfer after reset");
        do_reset();
        xfer_done(1'b1, 1'b0);
        rd(XFER_STAT_OFS, 32'h2, "xfer second reset");
        rd(FIRST_ERR_OFS, 32'h0, "first err after reset");
        $display("test reset_again done");

        close_out();
    end

endmodule : flash_setup_status_regs_tb_top
`default_nettype wire
